// file: include/ppc_map.svh
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
// ***********************************************************
// Register word offsets (byte addresses on the APB)
// ***********************************************************
`define OFF_CTRL      8'h00
`define OFF_CTRL_CLR  8'h04
`define OFF_CTRL_SET  8'h08
`define OFF_CTRL_INV  8'h0c
`define OFF_MODE      8'h10
`define OFF_ADDR      8'h20
`define OFF_WDATA     8'h30
`define OFF_RCMD      8'h34
`define OFF_RDATA     8'h38
`define OFF_STAT      8'h40
// ***********************************************************
// Control register fields, masks and reset values
// ***********************************************************
`define CTRL_WMASK    32'h0000_bffb
`define CTRL_RESET    32'h0000_0000
`define B_ON          15
`define B_STOP_IN_IDLE        13
`define B_MUX_HI      12
`define B_MUX_LO      11
`define B_WREN        9
`define B_RDEN        8
`define B_CSF_HI      7
`define B_CSF_LO      6
`define B_ALP         5
`define B_CHIP_SELECT2_POLARITY        4
`define B_CS1P        3
`define B_WRSP        1
`define B_RDSP        0
`define MUX_SEP       2'b00
`define MUX_LO8       2'b01
`define MUX_ALL16     2'b10
`define MUX_WIDE      2'b11
`define CSF_ADDR      2'b00
`define CSF_CS2       2'b01
`define CSF_BOTH      2'b10
// ***********************************************************
// Mode register fields and buffer shape
// ***********************************************************
`define MODE_RESET    3'h0
`define B_DATA16      0
`define B_COMBINED    1
`define B_FREEZE      2
`define FIFO_DEPTH    8
`define XFER_W        33
`endif

// file: include/ppc_pkg.sv
package ppc_pkg;
  // ***********************************************************
  // Bus cycle phases toward the external peripheral
  // ***********************************************************
  typedef enum logic [2:0]
  {
    PH_IDLE   = 3'b000,
    PH_ALO    = 3'b001,
    PH_AHI    = 3'b010,
    PH_STROBE = 3'b011,
    PH_DONE   = 3'b100
  } phase_t;
  // One queued off-chip access
  typedef struct packed
  {
    logic        rd;
    logic [15:0] addr;
    logic [15:0] data;
  } xfer_t;
  // Everything the port drives toward the pins except the address and strobe drive enables
  typedef struct packed
  {
    logic [15:0] pd;
    logic [15:0] pd_oe;
    logic [15:0] pa;
    logic        cs1;
    logic        cs2;
    logic        all;
    logic        alh;
    logic        wr;
    logic        rd;
  } pins_t;
endpackage

// file: logic/ppc_fifo.sv
`include "ppc_map.svh"
module ppc_fifo #(
  parameter int WIDTH = `XFER_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  logic                     pclk,      // Bus clock
  input  logic                     presetn,   // Async reset, low
  input  logic [WIDTH-1:0]         in_data,   // Word to store
  input  logic                     in_valid,  // Word offered
  output logic                     in_ready,  // Room left
  output logic [WIDTH-1:0]         out_data,  // Oldest word
  output logic                     out_valid, // Word held
  input  logic                     out_ready, // Word taken
  output logic [$clog2(DEPTH):0]   level      // Words held
);
  // ***********************************************************
  // Pointers carry one extra bit so full and empty differ
  // ***********************************************************
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage, flip-flops
  logic [AW:0]      wr_ptr_ff;       // Write pointer
  logic [AW:0]      rd_ptr_ff;       // Read pointer
  logic             push;            // Word stored this edge
  logic             pop;             // Word removed this edge

  assign level     = wr_ptr_ff - rd_ptr_ff;
  assign in_ready  = level != (AW + 1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Data storage needs no reset; level guards stale words
  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // Pointer updates; DEPTH must be a power of two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + (AW + 1)'(push);
      rd_ptr_ff <= rd_ptr_ff + (AW + 1)'(pop);
    end
  end
endmodule

// file: logic/ppc_pin_format.sv
`include "ppc_map.svh"
module ppc_pin_format
  import ppc_pkg::*;
(
  input  phase_t      phase, // Current cycle phase
  input  xfer_t       cur,   // Access in flight
  input  logic [31:0] ctrl,  // Control register
  input  logic [2:0]  mode,  // Mode register
  output pins_t       pins   // Next pin levels
);
  // ***********************************************************
  // Pin levels for each phase, before output registering
  // ***********************************************************
  always_comb
  begin
    logic [1:0] mux;
    logic [1:0] chip_select_function;
    logic       act;
    logic       st;
    logic       lo;
    logic       hi;
    logic       d16;
    mux  = ctrl[`B_MUX_HI:`B_MUX_LO];
    chip_select_function  = ctrl[`B_CSF_HI:`B_CSF_LO];
    act  = phase != PH_IDLE;
    st   = phase == PH_STROBE;
    lo   = phase == PH_ALO;
    hi   = (phase == PH_AHI) | (lo & (mux == `MUX_WIDE));
    d16  = mode[`B_DATA16];
    pins = '0;
    // Address lines carry what the data lines do not
    if (mux == `MUX_SEP)
      pins.pa = cur.addr; // R3 R13
    else if (mux == `MUX_ALL16)
      pins.pa = 16'h0000; // R3
    else
      pins.pa = {cur.addr[15:8], 8'h00}; // R3
    // Data lines: address phases, then write data held to the end
    unique case (phase)
      PH_ALO:
      begin
        pins.pd    = {8'h00, cur.addr[7:0]}; // R3
        pins.pd_oe = (mux == `MUX_WIDE) ? 16'hffff : 16'h00ff; // R3
      end
      PH_AHI:
      begin
        pins.pd    = {8'h00, cur.addr[15:8]}; // R3
        pins.pd_oe = 16'h00ff;
      end
      PH_STROBE, PH_DONE:
      begin
        if (!cur.rd)
        begin
          pins.pd    = d16 ? cur.data : {8'h00, cur.data[7:0]}; // R12
          pins.pd_oe = d16 ? 16'hffff : 16'h00ff; // R12
        end
      end
      PH_IDLE:
      begin
        pins.pd    = 16'h0000;
        pins.pd_oe = 16'h0000;
      end
      default:
      begin
        pins.pd    = 16'h0000;
        pins.pd_oe = 16'h0000;
      end
    endcase
    pins.all = ctrl[`B_ALP] ? lo : ~lo; // R7
    pins.alh = ctrl[`B_ALP] ? hi : ~hi; // R7
    // Lines in address use ignore function polarity bits
    if (chip_select_function == `CSF_BOTH)
      pins.cs1 = ctrl[`B_CS1P] ? act : ~act; // R6
    else
      pins.cs1 = cur.addr[14]; // R6 R9
    if (chip_select_function == `CSF_CS2 || chip_select_function == `CSF_BOTH)
      pins.cs2 = ctrl[`B_CHIP_SELECT2_POLARITY] ? act : ~act; // R6 R8
    else
      pins.cs2 = cur.addr[15]; // R6 R9
    // Strobe schemes: direction plus enable, or split strobes
    if (mode[`B_COMBINED])
    begin
      pins.rd = cur.rd; // R14
      pins.wr = ctrl[`B_WRSP] ? st : ~st; // R14
    end
    else
    begin
      pins.rd = ctrl[`B_RDSP] ? (st & cur.rd) : ~(st & cur.rd); // R14
      pins.wr = ctrl[`B_WRSP] ? (st & ~cur.rd) : ~(st & ~cur.rd); // R14
    end
  end
endmodule

// file: logic/parallel_master_module.sv
// Behaviour
// R1 - Enable bit 15 gates all off-chip access
// R2 - Stop-in-idle bit 13 halts during Idle
// R3 - Mux field 12:11 places address on lines
// R4 - Bit 9 enables write/enable strobe pin
// R5 - Bit 8 enables read/direction strobe pin
// R6 - Field 7:6 picks chip select or address
// R7 - Bit 5 sets both latch strobe polarities
// R8 - Bit 4 sets chip select 2 polarity
// R9 - Address-mode pins ignore function and polarity
// R10 - Software avoids access right after disable
// R11 - Bits 31:16 and 14 read zero
// R12 - Data width selectable, 8 or 16
// R13 - Sixteen address lines, two chip selects
// R14 - Split strobes or direction plus enable
// R15 - Port keeps running in Sleep/Idle
// R16 - Clear, set, invert companion addresses
// R17 - Freeze halts port under debug halt
// R18 - Reset clears every control bit
//
// The APB slave port and the address map were chosen for this implementation.
`include "ppc_map.svh"
module parallel_master_module
  import ppc_pkg::*;
(
  input  logic        pclk,                      // Bus clock, 100 MHz
  input  logic        presetn,                   // Async reset, low
  input  logic [7:0]  paddr,                     // APB byte address
  input  logic        psel,                      // APB select
  input  logic        penable,                   // APB access phase
  input  logic        pwrite,                    // APB direction
  input  logic [31:0] pwdata,                    // APB write data
  output logic        pready,                    // APB ready
  output logic [31:0] prdata,                    // APB read data
  output logic        pslverr,                   // APB error
  input  logic        idle_mode,                 // Processor in Idle
  input  logic        debug_halt,                // Debugger halted core
  input  logic [15:0] parallel_data_lines_in,    // Data pins in
  output logic [15:0] parallel_data_lines_out,   // Data pins out
  output logic [15:0] parallel_data_lines_oe,    // Data pins drive
  output logic [15:0] parallel_address_lines,    // Address pins
  output logic        parallel_address_lines_oe, // Address/select drive
  output logic        chip_select_line_1,        // Select 1 or A14
  output logic        chip_select_line_2,        // Select 2 or A15
  output logic        addr_latch_low_strobe,     // Low address latch
  output logic        addr_latch_high_strobe,    // High address latch
  output logic        write_strobe_pin,          // Write or enable
  output logic        write_strobe_pin_oe,       // Write pin drive
  output logic        read_strobe_pin,           // Read or direction
  output logic        read_strobe_pin_oe         // Read pin drive
);
  // ***********************************************************
  // Declarations
  // ***********************************************************
  logic [31:0] ctrl_ff;      // Control register
  logic [2:0]  mode_ff;      // Width, strobe scheme, freeze
  logic [15:0] addr_ff;      // Address for next queued access
  logic [15:0] rdata_ff;     // Last data read off chip
  logic [31:0] prdata_ff;    // Read word caught in setup
  phase_t      phase_ff;     // Cycle phase
  phase_t      nxt_phase;    // Next cycle phase
  xfer_t       cur_ff;       // Access in flight
  pins_t       fmt;          // Formatted pin levels
  pins_t       pins_ff;      // Registered pin levels
  logic        pin_on_ff;    // Drive enable for address/select
  logic        wr_oe_ff;     // Write strobe pin drive
  logic        rd_oe_ff;     // Read strobe pin drive
  logic        setup;        // APB setup cycle
  logic        access;       // APB access cycle
  logic        push_sel;     // Address queues an access
  logic        wr_en;        // Write takes effect this edge
  logic        running;      // Port may start a cycle
  logic        start;        // Queued access taken now
  logic        fifo_in_rdy;  // Buffer has room
  logic        fifo_out_vld; // Buffer holds an access
  logic [3:0]  fifo_level;   // Words buffered
  xfer_t       fifo_in;      // Access offered to buffer
  xfer_t       fifo_out;     // Oldest buffered access
  logic [1:0]  mux;          // Address/data mux field

  // ***********************************************************
  // Helpers
  // ***********************************************************
  // Write, clear, set or invert through the companion words
  function automatic logic [31:0] apply_cmp(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [7:0]  a);
    logic [31:0] m;
    m = wd & `CTRL_WMASK;
    unique case (a)
      `OFF_CTRL_CLR: apply_cmp = old & ~m;
      `OFF_CTRL_SET: apply_cmp = old | m;
      `OFF_CTRL_INV: apply_cmp = old ^ m;
      default:       apply_cmp = m;
    endcase
  endfunction

  // Decodes every address the slave answers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `OFF_CTRL) || (a == `OFF_CTRL_CLR) ||
                (a == `OFF_CTRL_SET) || (a == `OFF_CTRL_INV) ||
                (a == `OFF_MODE) || (a == `OFF_ADDR) ||
                (a == `OFF_WDATA) || (a == `OFF_RCMD) ||
                (a == `OFF_RDATA) || (a == `OFF_STAT);
  endfunction

  // ***********************************************************
  // APB slave
  // ***********************************************************
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign push_sel = (paddr == `OFF_WDATA) || (paddr == `OFF_RCMD);
  // A queueing write waits while the buffer is full
  assign pready   = ~(push_sel & pwrite) | fifo_in_rdy;
  assign wr_en    = access & pwrite & pready;
  assign pslverr  = access & ~is_mapped(paddr);
  assign prdata   = prdata_ff;
  assign mux      = ctrl_ff[`B_MUX_HI:`B_MUX_LO];

  // Read word is caught in setup so access ends at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (setup && !pwrite)
    begin
      unique case (paddr)
        `OFF_CTRL, `OFF_CTRL_CLR, `OFF_CTRL_SET, `OFF_CTRL_INV:
          prdata_ff <= ctrl_ff & `CTRL_WMASK; // R11
        `OFF_MODE:  prdata_ff <= {29'h0000_0000, mode_ff};
        `OFF_ADDR:  prdata_ff <= {16'h0000, addr_ff};
        `OFF_RDATA: prdata_ff <= {16'h0000, rdata_ff};
        `OFF_STAT:
          prdata_ff <= {25'h000_0000, phase_ff != PH_IDLE, ~fifo_in_rdy,
                        ~fifo_out_vld, fifo_level};
        default:    prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Control register, write and companion words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= `CTRL_RESET; // R18
    else if (wr_en && (paddr == `OFF_CTRL || paddr == `OFF_CTRL_CLR ||
                       paddr == `OFF_CTRL_SET || paddr == `OFF_CTRL_INV))
      ctrl_ff <= apply_cmp(ctrl_ff, pwdata, paddr); // R16 R11
  end

  // Mode and address registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff <= `MODE_RESET;
      addr_ff <= 16'h0000;
    end
    else if (wr_en)
    begin
      if (paddr == `OFF_MODE)
        mode_ff <= pwdata[2:0];
      if (paddr == `OFF_ADDR)
        addr_ff <= pwdata[15:0]; // R13
    end
  end

  // ***********************************************************
  // Access buffer
  // ***********************************************************
  assign fifo_in = '{rd: paddr == `OFF_RCMD, addr: addr_ff, data: pwdata[15:0]};

  ppc_fifo #(
    .WIDTH (`XFER_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   (fifo_in),
    .in_valid  (access & pwrite & push_sel),
    .in_ready  (fifo_in_rdy),
    .out_data  (fifo_out),
    .out_valid (fifo_out_vld),
    .out_ready (start),
    .level     (fifo_level)
  );

  // ***********************************************************
  // Cycle engine
  // ***********************************************************
  // Idle and debug halts only stop new cycles; one in flight ends
  assign running = ctrl_ff[`B_ON] // R1 R15
                 & ~(ctrl_ff[`B_STOP_IN_IDLE] & idle_mode) // R2
                 & ~(mode_ff[`B_FREEZE] & debug_halt); // R17
  assign start   = (phase_ff == PH_IDLE) & running & fifo_out_vld;

  // Next phase; separate pins skip the latch phases
  always_comb
  begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PH_IDLE:
        if (start)
          nxt_phase = (mux == `MUX_SEP) ? PH_STROBE : PH_ALO; // R3
      PH_ALO:
        nxt_phase = (mux == `MUX_ALL16) ? PH_AHI : PH_STROBE; // R3
      PH_AHI:
        nxt_phase = PH_STROBE;
      PH_STROBE:
        nxt_phase = PH_DONE;
      PH_DONE:
        nxt_phase = PH_IDLE;
      default:
        nxt_phase = PH_IDLE;
    endcase
  end

  // Phase register; clearing the enable abandons the cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_ff <= PH_IDLE;
    else if (!ctrl_ff[`B_ON])
      phase_ff <= PH_IDLE; // R1
    else
      phase_ff <= nxt_phase;
  end

  // Access in flight, loaded as it leaves the buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ff <= '0;
    else if (start)
      cur_ff <= fifo_out;
  end

  // Read data sampled while the strobe stands on the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_ff <= 16'h0000;
    else if (phase_ff == PH_DONE && cur_ff.rd)
      rdata_ff <= mode_ff[`B_DATA16] ? parallel_data_lines_in // R12
                : {8'h00, parallel_data_lines_in[7:0]};
  end

  // ***********************************************************
  // Pin drive
  // ***********************************************************
  ppc_pin_format u_fmt (
    .phase (phase_ff),
    .cur   (cur_ff),
    .ctrl  (ctrl_ff),
    .mode  (mode_ff),
    .pins  (fmt)
  );

  // Pins are registered so they never glitch on decode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_ff   <= '0;
      pin_on_ff <= 1'b0;
      wr_oe_ff  <= 1'b0;
      rd_oe_ff  <= 1'b0;
    end
    else
    begin
      pins_ff       <= fmt;
      pins_ff.pd_oe <= ctrl_ff[`B_ON] ? fmt.pd_oe : 16'h0000; // R1
      pin_on_ff     <= ctrl_ff[`B_ON]; // R1
      wr_oe_ff      <= ctrl_ff[`B_ON] & ctrl_ff[`B_WREN]; // R4
      rd_oe_ff      <= ctrl_ff[`B_ON] & ctrl_ff[`B_RDEN]; // R5
    end
  end

  assign parallel_data_lines_out   = pins_ff.pd;
  assign parallel_data_lines_oe    = pins_ff.pd_oe;
  assign parallel_address_lines    = pins_ff.pa;
  assign parallel_address_lines_oe = pin_on_ff;
  assign chip_select_line_1        = pins_ff.cs1;
  assign chip_select_line_2        = pins_ff.cs2;
  assign addr_latch_low_strobe     = pins_ff.all;
  assign addr_latch_high_strobe    = pins_ff.alh;
  assign write_strobe_pin          = pins_ff.wr;
  assign write_strobe_pin_oe       = wr_oe_ff;
  assign read_strobe_pin           = pins_ff.rd;
  assign read_strobe_pin_oe        = rd_oe_ff;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_off_idle;
    !ctrl_ff[`B_ON] |=> phase_ff == PH_IDLE;
  endproperty
  a_off_idle: assert property (p_off_idle) // R1
    else $error("cycle running while disabled");

  property p_off_pins;
    !ctrl_ff[`B_ON] |=> parallel_data_lines_oe == 16'h0000 && !write_strobe_pin_oe;
  endproperty
  a_off_pins: assert property (p_off_pins) // R1
    else $error("pins driven while disabled");

  property p_stop_in_idle_stop;
    (phase_ff == PH_IDLE && ctrl_ff[`B_STOP_IN_IDLE] && idle_mode) |=> phase_ff == PH_IDLE;
  endproperty
  a_stop_in_idle_stop: assert property (p_stop_in_idle_stop) // R2
    else $error("cycle started in idle with stop set");

  property p_idle_run;
    (phase_ff == PH_IDLE && ctrl_ff[`B_ON] && !ctrl_ff[`B_STOP_IN_IDLE] && !debug_halt
     && fifo_out_vld) |=> phase_ff != PH_IDLE;
  endproperty
  a_idle_run: assert property (p_idle_run) // R15
    else $error("queued access not started");

  property p_freeze;
    (phase_ff == PH_IDLE && mode_ff[`B_FREEZE] && debug_halt) |=> phase_ff == PH_IDLE;
  endproperty
  a_freeze: assert property (p_freeze) // R17
    else $error("cycle started while frozen");

  property p_mux16;
    (phase_ff == PH_ALO && mux == `MUX_ALL16 && ctrl_ff[`B_ON])
      |=> phase_ff == PH_AHI ##1 phase_ff == PH_STROBE;
  endproperty
  a_mux16: assert property (p_mux16) // R3
    else $error("high address phase missing");

  property p_wren;
    !ctrl_ff[`B_WREN] |=> !write_strobe_pin_oe;
  endproperty
  a_wren: assert property (p_wren) // R4
    else $error("write strobe pin driven while disabled");

  property p_rden;
    !ctrl_ff[`B_RDEN] |=> !read_strobe_pin_oe;
  endproperty
  a_rden: assert property (p_rden) // R5
    else $error("read strobe pin driven while disabled");

  property p_alp;
    phase_ff == PH_IDLE |=> addr_latch_low_strobe == !$past(ctrl_ff[`B_ALP]);
  endproperty
  a_alp: assert property (p_alp) // R7
    else $error("latch strobe idle level wrong");

  property p_chip_select2_polarity;
    (phase_ff == PH_IDLE && ctrl_ff[`B_CSF_HI:`B_CSF_LO] == `CSF_BOTH)
      |=> chip_select_line_2 == !$past(ctrl_ff[`B_CHIP_SELECT2_POLARITY]);
  endproperty
  a_chip_select2_polarity: assert property (p_chip_select2_polarity) // R8
    else $error("chip select 2 idle level wrong");

  property p_cs_addr;
    ctrl_ff[`B_CSF_HI:`B_CSF_LO] == `CSF_ADDR |=> chip_select_line_2 == $past(cur_ff.addr[15]);
  endproperty
  a_cs_addr: assert property (p_cs_addr) // R9
    else $error("address line used polarity");

  property p_rsvd_zero;
    (setup && !pwrite && paddr == `OFF_CTRL) |=> prdata[31:16] == 16'h0000 && !prdata[14];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // R11
    else $error("unimplemented control bits read nonzero");

  property p_set;
    (wr_en && paddr == `OFF_CTRL_SET)
      |=> ctrl_ff == ($past(ctrl_ff) | ($past(pwdata) & `CTRL_WMASK));
  endproperty
  a_set: assert property (p_set) // R16
    else $error("set companion failed");
endmodule

// file: verif/ppc_peripheral.sv
// ***********************************************************
// External device answering reads on the data pins
// ***********************************************************
module ppc_peripheral (
  input  wire logic        pclk,     // Bus clock
  input  wire logic        rd_pin,   // Read strobe, active low
  input  wire logic [15:0] rd_value, // Word served on reads
  output logic      [15:0] data_in   // Level seen on data pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] flip = 16'h0000; // Junk pattern when released
  // Released bus flips each cycle so stale data can never match
  always @(posedge pclk)
    flip <= ~flip;
  // Drives only while the strobe stands
  assign data_in = (rd_pin === 1'b0) ? rd_value : flip;
endmodule

// file: verif/tb_parallel_master_module.sv
module tb_parallel_master_module;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        idle_mode, debug_halt, cs1, cs2, wr_s, wr_oe, rd_s;
  logic        rd_oe, pa_oe, lat_lo, lat_hi;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] din, dout, dout_oe, pa;
  int          n_errors, n_tests, lows;
  parallel_master_module i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .idle_mode(idle_mode), .debug_halt(debug_halt),
    .parallel_data_lines_in(din), .parallel_data_lines_out(dout),
    .parallel_data_lines_oe(dout_oe), .parallel_address_lines(pa),
    .parallel_address_lines_oe(pa_oe), .chip_select_line_1(cs1), .chip_select_line_2(cs2),
    .addr_latch_low_strobe(lat_lo), .addr_latch_high_strobe(lat_hi), .write_strobe_pin(wr_s),
    .write_strobe_pin_oe(wr_oe), .read_strobe_pin(rd_s), .read_strobe_pin_oe(rd_oe));
  ppc_peripheral i_peer (.pclk(pclk), .rd_pin(rd_s), .rd_value(16'h00c3), .data_in(din));
  // ***********************************************************
  // Clock, bus tasks and checks
  // ***********************************************************
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // One APB transfer; waits on pready, no cycle count assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog cuts a hung handshake short
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
  // ***********************************************************
  // Test sequence
  // ***********************************************************
  initial
  begin
    {psel, penable, pwrite, debug_halt, presetn} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    idle_mode = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1, 8'h00, 32'hffff_ffff);
    apb(0, 8'h00, 0);
    chk(rd, 32'h0000_bffb, "ctrl");
    apb(1, 8'h04, 32'hffff_ffff);
    apb(0, 8'h00, 0);
    chk(rd, 32'h0, "clr");
    apb(1, 8'h08, 32'h0000_2310);
    apb(1, 8'h20, 32'h1234);
    apb(1, 8'h30, 32'h5a5a);
    apb(1, 8'h0c, 32'h0000_8080);
    apb(0, 8'h00, 0);
    chk(rd, 32'h0000_a390, "inv");
    // Stop-in-idle holds the queued write back while idle is high
    lows = 0;
    repeat (12)
    begin
      @(posedge pclk);
      lows += (wr_s === 1'b0);
    end
    chk(lows, 0, "idle strobes");
    idle_mode <= 1'b0;
    for (int i = 0; i < 40 && wr_s !== 1'b0; i++) @(posedge pclk);
    chk(wr_s, 1'b0, "write strobe");
    chk(dout, 16'h005a, "data 8 bit");
    chk(dout_oe, 16'h00ff, "data drive 8 bit");
    chk({cs1, cs2}, 2'b01, "selects");
    chk(pa, 16'h1234, "address");
    apb(1, 8'h34, 0);
    for (int i = 0; i < 20; i++)
    begin
      apb(0, 8'h40, 0);
      if (rd[4] && !rd[6])
        break;
    end
    apb(0, 8'h38, 0);
    chk(rd, 32'h0000_00c3, "read data");
    apb(1, 8'h04, 32'h0000_8000);
    repeat (2) @(posedge pclk);
    chk(wr_oe, 1'b0, "disabled");
    chk({rd_oe, pa_oe, dout_oe}, 32'h0, "disabled pins");
    apb(0, 8'hfc, 0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    // Freeze holds a queued 16-bit write; mux 10 and combined strobes
    debug_halt <= 1'b1;
    apb(1, 8'h10, 32'h7);
    apb(1, 8'h08, 32'h0000_9020);
    apb(1, 8'h30, 32'hbeef);
    lows = 0;
    repeat (8)
    begin
      @(posedge pclk);
      lows += (lat_lo !== 1'b0);
    end
    chk(lows, 0, "frozen");
    debug_halt <= 1'b0;
    for (int i = 0; i < 40 && lat_lo !== 1'b1; i++) @(posedge pclk);
    chk({lat_lo, lat_hi}, 2'b10, "latch low");
    chk({dout, dout_oe}, 32'h0034_00ff, "address low byte");
    chk(pa, 16'h0000, "no address pins");
    chk({wr_oe, rd_oe, pa_oe}, 3'b111, "pin drive");
    @(posedge pclk);
    chk({lat_lo, lat_hi, dout}, {2'b01, 16'h0012}, "latch high");
    @(posedge pclk);
    chk({wr_s, rd_s}, 2'b00, "combined strobes");
    chk({dout, dout_oe}, 32'hbeef_ffff, "data 16 bit");
    stop_test();
  end
endmodule
